// file: fcts_supervisor.v
// Fieldbus control timeout supervisor with AXI4-Lite registers
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "fcts_defs.vh"
module fcts_supervisor #(
   parameter TICK_CYC = `FCTS_TICK_CYC
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Telegram and network variable update strobes
   input  wire        telegram_valid,
   input  wire        net_in_start_stop,
   input  wire        net_in_fault_clear,
   input  wire        net_in_command_word,
   input  wire        net_in_speed_setpoint,
   input  wire        net_in_percent_reference,
   input  wire        net_in_hertz_reference,
   // Command bits from bus and from terminals
   input  wire        bus_coast,
   input  wire        bus_dc_brake,
   input  wire        di_coast,
   input  wire        di_dc_brake,
   // Supervisor outputs
   output reg         link_timeout,
   output reg  [4:0]  timeout_action,
   output reg         setup_override,
   output reg  [1:0]  override_setup,
   output reg         timeout_warning,
   output reg         coast_cmd,
   output reg         dc_brake_cmd,
   output reg  [3:0]  command_word_profile,
   output reg  [1:0]  diag_trigger,
   output reg         irq
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [1:0] di_s1_q;
   reg [1:0] di_s2_q;
   // Terminals are asynchronous; two stages before use
   always @(posedge aclk) begin
      if (!aresetn) begin
         di_s1_q <= 2'b00;
         di_s2_q <= 2'b00;
      end else begin
         di_s1_q <= {di_dc_brake, di_coast};
         di_s2_q <= di_s1_q;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Configuration held by software
   reg [17:0] tout_q;
   reg [4:0]  act_q;
   reg [2:0]  mode_q;
   reg [11:0] src_q;
   reg [1:0]  irq_q;
   reg [1:0]  mask_q;
   reg        rst_cmd_q;

   // Write address and data parked until both are in
   reg [7:0]  awaddr_q;
   reg        aw_got_q;
   reg [31:0] wdata_q;
   reg        w_got_q;

   // Commit waits while a response is still unanswered
   wire       wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
   wire       n2_en = mode_q[`FCTS_MODE_N2];
   wire       net_en = mode_q[`FCTS_MODE_NET];

   // Accepted action code: unknown codes and code 20 without N2 are refused
   function act_ok;
      input [4:0] code;
      input       n2;
      begin
         act_ok = (code <= `FCTS_ACT_TRIP) ||
                  (code >= `FCTS_ACT_SU1 && code <= `FCTS_ACT_SU4) ||
                  (code == `FCTS_ACT_N2 && n2);
      end
   endfunction

   // Source selector decode shared by coasting and DC brake
   function sel_cmd;
      input [1:0] sel;
      input       bus;
      input       di;
      begin
         case (sel)
            `FCTS_SEL_DI:  sel_cmd = di;
            `FCTS_SEL_BUS: sel_cmd = bus;
            `FCTS_SEL_AND: sel_cmd = bus & di;
            default:       sel_cmd = bus | di;
         endcase
      end
   endfunction

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   // One-cycle timer events, latched into the sticky bits
   reg        ev_tout;
   reg        ev_end;

   // Address and data captured in either order; response after both
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         tout_q        <= `FCTS_RST_TOUT;
         act_q         <= `FCTS_RST_ACT;
         mode_q        <= `FCTS_RST_MODE;
         src_q         <= `FCTS_RST_SRC;
         mask_q        <= 2'b00;
         rst_cmd_q     <= 1'b0;
         irq_q         <= 2'b00;
      end else begin
         // Ready pulses once per offer, never twice in a row
         s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         // Reset command is a one-cycle pulse, reads back as zero
         rst_cmd_q <= 1'b0;
         // Response stands until the master takes it
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // Commit; refused writes answer SLVERR and change nothing
         if (wr_go) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            case ({awaddr_q[7:2], 2'b00})
               `FCTS_A_TOUT: begin
                  // Period clamped to 0.1 s .. 18000 s in 0.1 s units
                  if (wdata_q[31:0] > {14'd0, `FCTS_TOUT_MAX})
                     tout_q <= `FCTS_TOUT_MAX;
                  else if (wdata_q[17:0] < `FCTS_TOUT_MIN)
                     tout_q <= `FCTS_TOUT_MIN;
                  else
                     tout_q <= wdata_q[17:0];
               end
               `FCTS_A_ACT:
                  if (act_ok(wdata_q[4:0], n2_en) && wdata_q[31:5] == 27'd0)
                     act_q <= wdata_q[4:0];
                  else
                     s_axi_bresp <= 2'b10;
               `FCTS_A_MODE: mode_q <= wdata_q[2:0];
               `FCTS_A_RST:  rst_cmd_q <= wdata_q[0];
               // Diagnosis code above 2 is clamped to 2
               `FCTS_A_SRC: begin
                  src_q[7:0]  <= wdata_q[7:0];
                  src_q[11:8] <= wdata_q[11:8];
                  if (wdata_q[7:6] > `FCTS_DIAG_MAX)
                     src_q[`FCTS_SRC_DIAG] <= `FCTS_DIAG_MAX;
               end
               `FCTS_A_MASK: mask_q <= wdata_q[1:0];
               // Status and command words ignore writes; flags clear below
               `FCTS_A_STAT, `FCTS_A_IRQ, `FCTS_A_CMD: ;
               default: s_axi_bresp <= 2'b10;
            endcase
         end
         // Sticky events; a new event wins over a write-one clear
         irq_q[`FCTS_IRQ_TOUT] <= ev_tout | (irq_q[`FCTS_IRQ_TOUT] &
            ~(wr_go && {awaddr_q[7:2], 2'b00} == `FCTS_A_IRQ && wdata_q[`FCTS_IRQ_TOUT]));
         irq_q[`FCTS_IRQ_END] <= ev_end | (irq_q[`FCTS_IRQ_END] &
            ~(wr_go && {awaddr_q[7:2], 2'b00} == `FCTS_A_IRQ && wdata_q[`FCTS_IRQ_END]));
      end
   end

   // ----------------------------------------
   // Tick divider and timeout counter
   // ----------------------------------------
   reg [31:0] div_q;
   reg [17:0] cnt_q;
   reg        tout_q_on;
   reg        hold_q;

   // Network inputs count only in the network variant
   wire       net_upd = net_in_start_stop | net_in_fault_clear | net_in_command_word |
                        net_in_speed_setpoint | net_in_percent_reference |
                        net_in_hertz_reference;
   wire       kick = telegram_valid | (net_en & net_upd);
   // One tick per 0.1 s worth of clock cycles
   wire       tick = (div_q == TICK_CYC - 1);

   // Only set-up switching actions can enter hold
   wire       is_su = (act_q >= `FCTS_ACT_SU1) && (act_q <= `FCTS_ACT_SU4);
   wire       off = (act_q == `FCTS_RST_ACT);

   // Timer restarts on every qualifying update, counts 0.1 s ticks
   always @(posedge aclk) begin
      if (!aresetn) begin
         div_q     <= 32'd0;
         cnt_q     <= 18'd0;
         tout_q_on <= 1'b0;
         hold_q    <= 1'b0;
         ev_tout   <= 1'b0;
         ev_end    <= 1'b0;
      end else begin
         ev_tout <= 1'b0;
         ev_end  <= 1'b0;
         // Count holds on reaching the period; a count above a lowered period runs on and wraps
         if (kick) begin
            div_q <= 32'd0;
            cnt_q <= 18'd0;
         end else if (tick) begin
            div_q <= 32'd0;
            if (cnt_q != tout_q)
               cnt_q <= cnt_q + 18'd1;
         end else begin
            div_q <= div_q + 32'd1;
         end

         // Expiry: time since last qualifying update reached the period
         if (!tout_q_on && !kick && cnt_q == tout_q && !off) begin
            tout_q_on <= 1'b1;
            ev_tout   <= 1'b1;
         end

         // End of timeout
         if (tout_q_on) begin
            // A reset command outside hold does nothing
            if (hold_q) begin
               if (rst_cmd_q) begin
                  hold_q    <= 1'b0;
                  tout_q_on <= 1'b0;
                  ev_end    <= 1'b1;
               end
            end else if (kick) begin
               if (is_su && !mode_q[`FCTS_MODE_REC]) begin
                  hold_q <= 1'b1;
               end else begin
                  tout_q_on <= 1'b0;
                  ev_end    <= 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   reg       coast_d;
   reg       brake_d;
   // Control site overrides per-function selectors
   always @* begin
      // Site code 3 falls to the default and acts as site 0
      case (src_q[`FCTS_SRC_SITE])
         `FCTS_SITE_DI: begin
            coast_d = di_s2_q[0];
            brake_d = di_s2_q[1];
         end
         `FCTS_SITE_WORD: begin
            coast_d = bus_coast;
            brake_d = bus_dc_brake;
         end
         default: begin
            coast_d = sel_cmd(src_q[`FCTS_SRC_COAST], bus_coast, di_s2_q[0]);
            brake_d = sel_cmd(src_q[`FCTS_SRC_BRAKE], bus_dc_brake, di_s2_q[1]);
         end
      endcase
   end

   // Registered outputs, set-up override held across the timeout
   always @(posedge aclk) begin
      if (!aresetn) begin
         link_timeout         <= 1'b0;
         timeout_action       <= 5'd0;
         setup_override       <= 1'b0;
         override_setup       <= 2'd0;
         timeout_warning      <= 1'b0;
         coast_cmd            <= 1'b0;
         dc_brake_cmd         <= 1'b0;
         command_word_profile <= 4'd0;
         diag_trigger         <= 2'd0;
         irq                  <= 1'b0;
      end else begin
         // Link state and action follow the timer one clock later
         link_timeout         <= tout_q_on;
         timeout_action       <= tout_q_on ? act_q : 5'd0;
         setup_override       <= tout_q_on & is_su;
         override_setup       <= act_q[1:0] - 2'd3;
         timeout_warning      <= hold_q;

         // Terminal path is three clocks deep, bus path one
         coast_cmd            <= coast_d;
         dc_brake_cmd         <= brake_d;
         command_word_profile <= src_q[`FCTS_SRC_PROF];
         diag_trigger         <= net_en ? 2'd0 : src_q[`FCTS_SRC_DIAG];

         // Level interrupt from unmasked sticky bits
         irq                  <= |(irq_q & mask_q);
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         // One read at a time; no new address while data stands
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;

         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            // Data captured at the handshake, held until taken
            case ({s_axi_araddr[7:2], 2'b00})
               `FCTS_A_TOUT: s_axi_rdata <= {14'd0, tout_q};
               `FCTS_A_ACT:  s_axi_rdata <= {27'd0, act_q};
               `FCTS_A_MODE: s_axi_rdata <= {29'd0, mode_q};
               `FCTS_A_RST:  s_axi_rdata <= 32'h0000_0000;
               `FCTS_A_SRC:  s_axi_rdata <= {20'd0, src_q};
               `FCTS_A_STAT: s_axi_rdata <= {14'd0, cnt_q[15:0], hold_q, tout_q_on};
               `FCTS_A_IRQ:  s_axi_rdata <= {30'd0, irq_q};
               `FCTS_A_MASK: s_axi_rdata <= {30'd0, mask_q};
               `FCTS_A_CMD:  s_axi_rdata <= {30'd0, dc_brake_cmd, coast_cmd};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: fcts_defs.vh
// Constants for the fieldbus control timeout supervisor
`ifndef FCTS_DEFS_VH
`define FCTS_DEFS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define FCTS_CLK_HZ        250000000
`define FCTS_TICK_MS       100
`define FCTS_TICK_CYC      ((`FCTS_CLK_HZ / 1000) * `FCTS_TICK_MS)
`define FCTS_TOUT_MAX      18'd180000
`define FCTS_TOUT_MIN      18'd1
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FCTS_A_TOUT        8'h00
`define FCTS_A_ACT         8'h04
`define FCTS_A_MODE        8'h08
`define FCTS_A_RST         8'h0c
`define FCTS_A_SRC         8'h10
`define FCTS_A_STAT        8'h14
`define FCTS_A_IRQ         8'h18
`define FCTS_A_MASK        8'h1c
`define FCTS_A_CMD         8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCTS_MODE_REC      0
`define FCTS_MODE_N2       1
`define FCTS_MODE_NET      2
`define FCTS_SRC_COAST     1:0
`define FCTS_SRC_BRAKE     3:2
`define FCTS_SRC_SITE      5:4
`define FCTS_SRC_DIAG      7:6
`define FCTS_SRC_PROF      11:8
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define FCTS_RST_TOUT      18'd1
`define FCTS_RST_ACT       5'd0
`define FCTS_RST_SRC       12'h00f
`define FCTS_RST_MODE      3'h1
`define FCTS_ACT_FREEZE    5'd1
`define FCTS_ACT_STOP      5'd2
`define FCTS_ACT_JOG       5'd3
`define FCTS_ACT_MAX       5'd4
`define FCTS_ACT_TRIP      5'd5
`define FCTS_ACT_SU1       5'd7
`define FCTS_ACT_SU4       5'd10
`define FCTS_ACT_N2        5'd20
`define FCTS_SEL_DI        2'd0
`define FCTS_SEL_BUS       2'd1
`define FCTS_SEL_AND       2'd2
`define FCTS_SITE_BOTH     2'd0
`define FCTS_SITE_DI       2'd1
`define FCTS_SITE_WORD     2'd2
`define FCTS_DIAG_MAX      2'd2
`define FCTS_IRQ_TOUT      0
`define FCTS_IRQ_END       1
`endif

// file: fcts_sup_sva.sv
// Port assertions for the timeout supervisor
`timescale 1ns/100ps
`default_nettype none
module fcts_sup_sva (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshake
   input wire logic        s_axi_awready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Supervisor state
   input wire logic        link_timeout,
   input wire logic [4:0]  timeout_action,
   input wire logic        setup_override,
   input wire logic [1:0]  override_setup,
   input wire logic        timeout_warning,
   input wire logic [1:0]  diag_trigger
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Action code tracks the link state
   AST_ACT_IDLE: assert property (
      !link_timeout && !$past(link_timeout) |-> timeout_action == 5'd0)
      else $error("action code shown without timeout");
   AST_ACT_OFF: assert property (
      link_timeout && $past(link_timeout) |-> timeout_action != 5'd0)
      else $error("timeout raised with action off");
   AST_OVR_IDX: assert property (
      setup_override && link_timeout |-> timeout_action inside {[7:10]}
      && override_setup == 2'(timeout_action - 5'd7)) else $error("bad set-up index");
   // Hold state keeps the timeout set-up
   AST_WARN_SU: assert property (
      timeout_warning |-> setup_override) else $error("warning without set-up");
   AST_DIAG: assert property (
      diag_trigger <= 2'd2) else $error("diagnosis code out of range");
   // Bus answers stand until taken
   AST_B_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   AST_R_HOLD: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   AST_AW_PULSE: assert property (
      s_axi_awready |=> !s_axi_awready) else $error("awready not a pulse");
   AST_AR_PULSE: assert property (
      s_axi_arready |=> !s_axi_arready) else $error("arready not a pulse");
   // Main scenarios
   COV_TOUT: cover property ($rose(link_timeout));
   COV_HOLD: cover property (timeout_warning);
   COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'd2);
endmodule
bind fcts_supervisor fcts_sup_sva u_sva (
   .aclk, .aresetn, .s_axi_awready, .s_axi_arready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .link_timeout,
   .timeout_action, .setup_override, .override_setup, .timeout_warning, .diag_trigger);
`default_nettype wire

// file: fcts_bus_master.sv
// Fieldbus master model strobing telegrams or variable updates
`timescale 1ns/100ps
`default_nettype none
module fcts_bus_master (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Traffic control: which 6 means telegrams
   input wire logic        run,
   input wire logic [7:0]  gap,
   input wire logic [2:0]  which,
   // Update strobes
   output var logic        telegram_valid,
   output var logic [5:0]  net_upd
);
   logic [7:0] cnt_q;
   // One strobe every gap+1 cycles; silent when stopped
   always @(posedge aclk) begin
      if (!aresetn || !run) begin
         cnt_q <= 8'h00;
         telegram_valid <= 1'b0;
         net_upd <= 6'h00;
      end else begin
         cnt_q <= (cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
         telegram_valid <= (cnt_q == gap) && (which == 3'd6);
         net_upd <= (cnt_q == gap && which < 3'd6) ? 6'h01 << which : 6'h00;
      end
   end
endmodule
`default_nettype wire

// file: fcts_tb.sv
// Self-checking bench for the timeout supervisor
`timescale 1ns/100ps
`default_nettype none
`include "fcts_defs.vh"
module tb;
   localparam TK = 10;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, telegram_valid, bus_coast, bus_dc_brake, di_coast, di_dc_brake;
   logic run, link_timeout, setup_override, timeout_warning, coast_cmd, dc_brake_cmd, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, gap;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, command_word_profile;
   logic [1:0] s_axi_bresp, s_axi_rresp, override_setup, diag_trigger;
   logic [5:0] net_q;
   logic [4:0] timeout_action;
   logic [2:0] which;
   integer errors, num_checks, cyc, n, i, k, s, c;
   fcts_supervisor #(.TICK_CYC(TK)) u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .telegram_valid,
      .net_in_start_stop(net_q[0]), .net_in_fault_clear(net_q[1]),
      .net_in_command_word(net_q[2]), .net_in_speed_setpoint(net_q[3]),
      .net_in_percent_reference(net_q[4]), .net_in_hertz_reference(net_q[5]),
      .bus_coast, .bus_dc_brake, .di_coast, .di_dc_brake, .link_timeout,
      .timeout_action, .setup_override, .override_setup, .timeout_warning, .coast_cmd,
      .dc_brake_cmd, .command_word_profile, .diag_trigger, .irq);
   fcts_bus_master u_mst (
      .aclk, .aresetn, .run, .gap, .which, .telegram_valid, .net_upd(net_q));
   // 250 MHz clock
   always #2 aclk = ~aclk;
   // Hang guard
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         errors = errors + 1;
         conclude;
      end
   end
   task conclude;
      begin
         $display("checks %0d errors %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // Ready and answers are registered, so they are read at the falling edge
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      logic aw, w;
      logic [1:0] r;
      begin
         aw = 0;
         w = 0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         while (!(aw && w)) begin
            @(negedge aclk);
            aw = aw | (s_axi_awready === 1'b1);
            w = w | (s_axi_wready === 1'b1);
            @(posedge aclk);
            if (aw)
               s_axi_awvalid <= 1'b0;
            if (w)
               s_axi_wvalid <= 1'b0;
         end
         s_axi_bready <= 1'b1;
         aw = 0;
         while (!aw) begin
            @(negedge aclk);
            aw = (s_axi_bvalid === 1'b1);
            r = s_axi_bresp;
            @(posedge aclk);
         end
         s_axi_bready <= 1'b0;
         chk(r, er);
      end
   endtask
   task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
      logic t;
      logic [31:0] d;
      logic [1:0] r;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         t = 0;
         while (!t) begin
            @(negedge aclk);
            t = (s_axi_arready === 1'b1);
            @(posedge aclk);
         end
         s_axi_arvalid <= 1'b0;
         s_axi_rready <= 1'b1;
         t = 0;
         while (!t) begin
            @(negedge aclk);
            t = (s_axi_rvalid === 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
         end
         s_axi_rready <= 1'b0;
         chk(d, ed);
         chk(r, er);
      end
   endtask
   // Bounded wait on the link state; n holds the cycles spent
   task wait_lt(input logic v, input integer mx);
      begin
         n = 0;
         do begin
            @(negedge aclk);
            n = n + 1;
         end while (link_timeout !== v && n < mx);
         chk(link_timeout, v);
         @(posedge aclk);
      end
   endtask
   // Expected command after site and source selection
   function logic res(input integer st, input integer sl, input logic b, input logic d);
      if (st == 1)
         res = d;
      else if (st == 2)
         res = b;
      else if (sl == 0)
         res = d;
      else if (sl == 1)
         res = b;
      else if (sl == 2)
         res = b & d;
      else
         res = b | d;
   endfunction
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
      {s_axi_rready, bus_coast, bus_dc_brake, di_coast, di_dc_brake, run} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      s_axi_wstrb = 4'hf;
      gap = 8'h01;
      which = 3'd6;
      {errors, num_checks, cyc} = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values, refused and clamped accesses
      rd(`FCTS_A_TOUT, 1, 0);
      rd(`FCTS_A_ACT, 0, 0);
      rd(`FCTS_A_MODE, 1, 0);
      rd(`FCTS_A_SRC, 32'h00f, 0);
      rd(`FCTS_A_MASK, 0, 0);
      rd(8'h30, 0, 2);
      wr(8'h30, 1, 2);
      wr(`FCTS_A_TOUT, 0, 0);
      rd(`FCTS_A_TOUT, 1, 0);
      wr(`FCTS_A_TOUT, 180001, 0);
      rd(`FCTS_A_TOUT, 180000, 0);
      wr(`FCTS_A_ACT, 20, 2);
      wr(`FCTS_A_ACT, 6, 2);
      wr(`FCTS_A_MODE, 3, 0);
      wr(`FCTS_A_ACT, 20, 0);
      rd(`FCTS_A_ACT, 20, 0);
      // Silence with action off, then kept alive, then expiry time
      wr(`FCTS_A_ACT, 0, 0);
      wr(`FCTS_A_TOUT, 3, 0);
      repeat (5 * TK) @(posedge aclk);
      chk(link_timeout, 0);
      run <= 1'b1;
      wr(`FCTS_A_ACT, 2, 0);
      repeat (10 * TK) @(posedge aclk);
      chk(link_timeout, 0);
      run <= 1'b0;
      wait_lt(1, 8 * TK);
      chk(n >= 2 * TK && n <= 3 * TK + 6, 1);
      // Action codes 1 to 5 and 7 to 10 in hold mode
      run <= 1'b1;
      wr(`FCTS_A_MODE, 2, 0);
      wr(`FCTS_A_TOUT, 1, 0);
      wr(`FCTS_A_MASK, 1, 0);
      for (k = 1; k <= 10; k++) if (k != 6) begin
         wr(`FCTS_A_ACT, k, 0);
         wr(`FCTS_A_IRQ, 3, 0);
         run <= 1'b0;
         wait_lt(1, 4 * TK);
         chk(timeout_action, k);
         chk(setup_override, k > 6);
         if (k > 6)
            chk(override_setup, k - 7);
         @(posedge aclk);
         chk(irq, 1);
         wr(`FCTS_A_IRQ, 1, 0);
         repeat (2) @(posedge aclk);
         chk(irq, 0);
         run <= 1'b1;
         repeat (6) @(posedge aclk);
         if (k > 6) begin
            chk(timeout_warning, 1);
            chk(setup_override, 1);
            wr(`FCTS_A_RST, 1, 0);
            repeat (3) @(posedge aclk);
            chk(timeout_warning, 0);
            chk(setup_override, 0);
         end else
            chk(link_timeout, 0);
      end
      rd(`FCTS_A_RST, 0, 0);
      // Resume mode with the interrupt masked
      wr(`FCTS_A_MODE, 1, 0);
      wr(`FCTS_A_MASK, 0, 0);
      wr(`FCTS_A_ACT, 9, 0);
      wr(`FCTS_A_IRQ, 3, 0);
      run <= 1'b0;
      wait_lt(1, 4 * TK);
      chk(override_setup, 2);
      chk(irq, 0);
      rd(`FCTS_A_IRQ, 1, 0);
      run <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(setup_override, 0);
      chk(timeout_warning, 0);
      // Command sources for each site and selector
      for (s = 0; s < 3; s++) for (i = 0; i < 4; i++) begin
         wr(`FCTS_A_SRC, {s[1:0], i[1:0], i[1:0]}, 0);
         for (c = 0; c < 4; c++) begin
            bus_coast <= c[1];
            di_coast <= c[0];
            bus_dc_brake <= c[0];
            di_dc_brake <= c[1];
            repeat (5) @(posedge aclk);
            chk(coast_cmd, res(s, i, c[1], c[0]));
            chk(dc_brake_cmd, res(s, i, c[0], c[1]));
         end
      end
      // Diagnosis, profile and the network variant
      wr(`FCTS_A_SRC, 32'h5cf, 0);
      rd(`FCTS_A_SRC, 32'h58f, 0);
      chk(diag_trigger, 2);
      chk(command_word_profile, 5);
      wr(`FCTS_A_MODE, 5, 0);
      repeat (2) @(posedge aclk);
      chk(diag_trigger, 0);
      for (k = 0; k < 6; k++) begin
         which <= k[2:0];
         repeat (10 * TK) @(posedge aclk);
         chk(link_timeout, 0);
      end
      run <= 1'b0;
      wait_lt(1, 4 * TK);
      run <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(link_timeout, 0);
      wr(`FCTS_A_MODE, 1, 0);
      wait_lt(1, 4 * TK);
      conclude;
   end
endmodule
`default_nettype wire
